/* File: ivp_ctrl.sv */
// vector table placement control with timed unlock and interrupt blocking
// assumes: core drives the register port, instr_done pulses at each instruction end,
// fuses and lock bits are static while out of reset
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_ctrl #(
  parameter int VEC_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ivp_pkg::ivp_byte_t reg_addr,
  input wire ivp_pkg::ivp_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ivp_pkg::ivp_byte_t reg_rdata,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_fuse,
  input wire logic app_section_irq_lock,
  input wire logic boot_section_irq_lock,
  input wire ivp_pkg::ivp_addr_t pc,
  input wire logic instr_done,
  input wire logic global_irq_enable,
  input wire logic irq_request,
  input wire logic [VEC_W-1:0] vector_num,
  output logic irq_service,
  output logic irq_block,
  output logic lock_block,
  output logic vector_base_select,
  output ivp_pkg::ivp_addr_t vector_base,
  output ivp_pkg::ivp_addr_t vector_addr,
  output ivp_pkg::ivp_addr_t reset_addr
);
  import ivp_pkg::*;

  // reset value of the control byte, sliced per field
  localparam ivp_byte_t CTRL_RST = `IVP_CTRL_RST;
  ivp_state_t state_reg;
  ivp_state_t state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic sel_reg;
  logic sel_next;
  ivp_byte_t rdata_reg;
  ivp_addr_t base_reg;
  ivp_addr_t vaddr_reg;
  ivp_addr_t raddr_reg;
  ivp_addr_t boot_start;
  logic in_boot;
  logic ctrl_wr;
  logic arm_wr;
  logic commit_wr;
  logic unlocked;

  function automatic logic is_programmed(input logic bit_val);
    is_programmed = (bit_val == `IVP_FUSE_PROGRAMMED);
  endfunction

  function automatic ivp_addr_t slot_offset(input logic [VEC_W-1:0] n);
    slot_offset = ivp_addr_t'({n, 1'b0});
  endfunction

  // ************************************************************
  // boot section map
  // ************************************************************
  ivp_boot_map u_map (
    .boot_size_fuses(boot_size_fuses),
    .pc(pc),
    .boot_start(boot_start),
    .in_boot_section(in_boot)
  );

  // ************************************************************
  // register write decode
  // ************************************************************
  assign ctrl_wr = reg_wr && (reg_addr == `IVP_CTRL_OFS);
  assign unlocked = (state_reg == IVP_UNLOCKED);
  // a control write with unlock high arms or re-arms the window; in hold it counts only together with instr_done
  assign arm_wr = ctrl_wr && reg_wdata[`IVP_UNLOCK_BIT];
  // select value lands only inside the window and with unlock low
  assign commit_wr = ctrl_wr && unlocked && !reg_wdata[`IVP_UNLOCK_BIT];

  // ************************************************************
  // unlock window state machine
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      IVP_IDLE: begin
        if (arm_wr) begin
          state_next = IVP_UNLOCKED;
          cnt_next = `IVP_UNLOCK_CYCLES - 3'd1;
        end
      end
      IVP_UNLOCKED: begin
        if (commit_wr) begin
          state_next = IVP_HOLD;
          cnt_next = 3'd0;
        end else if (arm_wr) begin
          cnt_next = `IVP_UNLOCK_CYCLES - 3'd1;
        end else if (cnt_reg == 3'd0) begin
          state_next = IVP_IDLE;
        end else begin
          cnt_next = cnt_reg - 3'd1;
        end
      end
      IVP_HOLD: begin
        // write instruction ends in the commit cycle; wait for the next one
        if (instr_done) begin
          state_next = arm_wr ? IVP_UNLOCKED : IVP_IDLE;
          cnt_next = arm_wr ? (`IVP_UNLOCK_CYCLES - 3'd1) : 3'd0;
        end
      end
      default: begin
        state_next = IVP_IDLE;
        cnt_next = 3'd0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IVP_IDLE;
      cnt_reg <= 3'd0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ************************************************************
  // vector base select
  // ************************************************************
  always_comb begin
    sel_next = sel_reg;
    if (commit_wr) begin
      sel_next = reg_wdata[`IVP_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= CTRL_RST[`IVP_SEL_BIT];
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign vector_base_select = sel_reg;

  // ************************************************************
  // vector and reset addresses
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= `IVP_APP_START;
      vaddr_reg <= `IVP_APP_START;
      raddr_reg <= `IVP_APP_START;
    end else begin
      base_reg <= sel_reg ? boot_start : `IVP_APP_START;
      vaddr_reg <= (sel_reg ? boot_start : `IVP_APP_START) + slot_offset(vector_num);
      raddr_reg <= is_programmed(boot_reset_fuse) ? boot_start : `IVP_APP_START;
    end
  end

  assign vector_base = base_reg;
  assign vector_addr = vaddr_reg;
  assign reset_addr = raddr_reg;

  // ************************************************************
  // interrupt gating
  // ************************************************************
  // registered state only, so blocking starts the cycle after the arming write
  assign irq_block = (state_reg != IVP_IDLE);
  assign lock_block = (sel_reg && is_programmed(app_section_irq_lock) && !in_boot)
    || (!sel_reg && is_programmed(boot_section_irq_lock) && in_boot);
  // global enable is only read here, never written back
  assign irq_service = irq_request && global_irq_enable && !irq_block && !lock_block;

  // ************************************************************
  // register read port
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IVP_CTRL_OFS: begin
          rdata_reg <= 8'h00;
          rdata_reg[`IVP_SEL_BIT] <= sel_reg;
          rdata_reg[`IVP_UNLOCK_BIT] <= unlocked;
        end
        `IVP_STAT_OFS: begin
          rdata_reg <= 8'h00;
          rdata_reg[`IVP_STAT_UNLOCK_BIT] <= unlocked;
          rdata_reg[`IVP_STAT_HOLD_BIT] <= (state_reg == IVP_HOLD);
          rdata_reg[`IVP_STAT_LOCK_BIT] <= lock_block;
          rdata_reg[`IVP_STAT_BLOCK_BIT] <= irq_block;
          rdata_reg[`IVP_STAT_INBOOT_BIT] <= in_boot;
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      // data stand only in the cycle after the read
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_app_base;
    !vector_base_select |=> (vector_base == `IVP_APP_START);
  endproperty
  a_app_base: assert property (p_app_base) else $error("base not at flash start");

  property p_boot_base;
    vector_base_select |=> (vector_base == $past(boot_start));
  endproperty
  a_boot_base: assert property (p_boot_base) else $error("base not at boot start");

  property p_boot8k_first;
    (vector_base_select && boot_size_fuses == 2'b00 && vector_num == 1)
      |=> (vector_addr == `IVP_BOOT8K_FIRST_IRQ);
  endproperty
  a_boot8k_first: assert property (p_boot8k_first) else $error("first vector not at 0x1F002");

  property p_reset_boot;
    (rst_n && !boot_reset_fuse && boot_size_fuses == 2'b00) |=> (reset_addr == `IVP_BOOT8K_START);
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("reset address not boot start");

  property p_reset_app;
    boot_reset_fuse |=> (reset_addr == `IVP_APP_START);
  endproperty
  a_reset_app: assert property (p_reset_app) else $error("unprogrammed fuse moved reset");

  property p_timeout;
    (state_reg == IVP_IDLE && arm_wr) ##1 (!ctrl_wr) [*4] |-> irq_block ##1 !irq_block;
  endproperty
  a_timeout: assert property (p_timeout) else $error("block not exactly four cycles");

  property p_unlock_window;
    (state_reg == IVP_IDLE && arm_wr) ##1 (!ctrl_wr) [*3]
      |=> (unlocked && $past(unlocked) && $past(unlocked, 2) && $past(unlocked, 3));
  endproperty
  a_unlock_window: assert property (p_unlock_window) else $error("unlock window too short");

  property p_commit;
    commit_wr |=> (!unlocked && vector_base_select == $past(reg_wdata[`IVP_SEL_BIT]) && irq_block);
  endproperty
  a_commit: assert property (p_commit) else $error("select write not taken");

  property p_locked_write;
    (ctrl_wr && !unlocked) |=> $stable(vector_base_select);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("select changed while locked");

  property p_hold_end;
    (state_reg == IVP_HOLD && instr_done && !arm_wr) |=> !irq_block;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("block outlived next instruction");

  property p_service_gate;
    irq_service |-> (global_irq_enable && !irq_block);
  endproperty
  a_service_gate: assert property (p_service_gate) else $error("service during block");

  property p_app_lock;
    (vector_base_select && !app_section_irq_lock && !in_boot) |-> !irq_service;
  endproperty
  a_app_lock: assert property (p_app_lock) else $error("service in locked application code");

  property p_boot_lock;
    (!vector_base_select && !boot_section_irq_lock && in_boot) |-> !irq_service;
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("service in locked boot code");

  property p_slot;
    // sampled reset keeps the release edge out: address registers load one edge later
    rst_n |=> (vector_addr == vector_base + slot_offset($past(vector_num)));
  endproperty
  a_slot: assert property (p_slot) else $error("vector slot offset wrong");

  property p_arm_block;
    (state_reg == IVP_IDLE && arm_wr) |=> irq_block;
  endproperty
  a_arm_block: assert property (p_arm_block) else $error("no block after unlock");

  property p_block_no_service;
    irq_block |-> !irq_service;
  endproperty
  a_block_no_service: assert property (p_block_no_service) else $error("service while blocked");

  property p_hold_keep;
    (state_reg == IVP_HOLD && !instr_done) |=> irq_block;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("block ended before next instruction");

  property p_sel_only_commit;
    !commit_wr |=> $stable(vector_base_select);
  endproperty
  a_sel_only_commit: assert property (p_sel_only_commit) else $error("select changed without commit");

  property p_app_vec_first;
    (rst_n && !vector_base_select && vector_num == 1) |=> (vector_addr == `IVP_APP_START + 17'h00002);
  endproperty
  a_app_vec_first: assert property (p_app_vec_first) else $error("first vector not at 0x00002");

  property p_reset_size;
    (rst_n && !boot_reset_fuse) |=> (reset_addr == $past(boot_start));
  endproperty
  a_reset_size: assert property (p_reset_size) else $error("reset address not sized boot start");

  property p_window_closed;
    (state_reg == IVP_IDLE && !arm_wr) |=> !unlocked;
  endproperty
  a_window_closed: assert property (p_window_closed) else $error("unlock set without arming");

  property p_lock_source;
    lock_block |-> (vector_base_select ? (app_section_irq_lock == `IVP_FUSE_PROGRAMMED && !in_boot)
      : (boot_section_irq_lock == `IVP_FUSE_PROGRAMMED && in_boot));
  endproperty
  a_lock_source: assert property (p_lock_source) else $error("lock block without lock bit");

  property p_no_lock_service;
    lock_block |-> !irq_service;
  endproperty
  a_no_lock_service: assert property (p_no_lock_service) else $error("service while lock blocked");

  c_commit: cover property (arm_wr ##[1:4] commit_wr);
  c_timeout: cover property ((state_reg == IVP_IDLE && arm_wr) ##1 (!ctrl_wr) [*5]);
  c_lock: cover property (irq_request && global_irq_enable && lock_block);
  c_rearm: cover property (unlocked && arm_wr);
  c_hold_done: cover property (commit_wr ##[1:8] (state_reg == IVP_HOLD && instr_done));
endmodule

/* File: ivp_regs.svh */
// register offsets, field positions, reset values and cycle counts of the vector placement block
// assumes: included by bare name, byte-wide register port, one core clock at 50 MHz
// Overview of operation
// - with vector_base_select low the vector table sits at the start of program flash.
// - with vector_base_select high the vector table moves to the first word of the boot loader section.
// - the boot section start, and so the relocated base, follows the boot_size_fuses setting.
// - hardware clears vector_change_unlock four cycles after it was set, or at once on the select write.
// - interrupt service is blocked from the cycle unlock is set until the instruction after the select write ends.
// - if no select write follows the unlock, interrupts stay blocked for exactly four cycles.
// - the automatic blocking never touches the global interrupt enable bit of status_register.
// - vectors in boot section plus app_section_irq_lock programmed suppress interrupts while running application code.
// - vectors in application section plus boot_section_irq_lock programmed suppress interrupts in boot code.
// - an 8 Kbyte boot section starts at word 0x1F000 and its relocated vectors begin at 0x1F002.
// - a programmed boot_reset_fuse starts execution after reset at the boot section start instead of zero.
// - a fuse or lock bit reading one is unprogrammed, zero is programmed.
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// ************************************************************
// register map
// ************************************************************
`define IVP_CTRL_OFS 8'h00
`define IVP_STAT_OFS 8'h01
`define IVP_CTRL_RST 8'h00
`define IVP_UNLOCK_BIT 0
`define IVP_SEL_BIT 1
`define IVP_STAT_UNLOCK_BIT 0
`define IVP_STAT_HOLD_BIT 1
`define IVP_STAT_LOCK_BIT 2
`define IVP_STAT_BLOCK_BIT 3
`define IVP_STAT_INBOOT_BIT 4

// ************************************************************
// timing and addresses
// ************************************************************
`define IVP_UNLOCK_CYCLES 3'd4
`define IVP_BOOT8K_START 17'h1F000
`define IVP_BOOT8K_FIRST_IRQ 17'h1F002
`define IVP_APP_START 17'h00000
`define IVP_FUSE_PROGRAMMED 1'b0

`endif

/* File: ivp_pkg.sv */
// types shared by the vector placement block
// assumes: compiled before every module of the block
package ivp_pkg;
  typedef logic [16:0] ivp_addr_t;
  typedef logic [7:0] ivp_byte_t;
  typedef enum logic [1:0] {IVP_IDLE, IVP_UNLOCKED, IVP_HOLD} ivp_state_t;
endpackage

/* File: ivp_boot_map.sv */
// boot section start decode and section membership of the program counter
// assumes: fuses are static configuration, pc is the word address of the running instruction
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_boot_map #(
  parameter ivp_pkg::ivp_addr_t BOOT_START_SZ0 = `IVP_BOOT8K_START,
  parameter ivp_pkg::ivp_addr_t BOOT_START_SZ1 = 17'h1F800,
  parameter ivp_pkg::ivp_addr_t BOOT_START_SZ2 = 17'h1FC00,
  parameter ivp_pkg::ivp_addr_t BOOT_START_SZ3 = 17'h1FE00
) (
  input wire logic [1:0] boot_size_fuses,
  input wire ivp_pkg::ivp_addr_t pc,
  output ivp_pkg::ivp_addr_t boot_start,
  output logic in_boot_section
);
  import ivp_pkg::*;

  // ************************************************************
  // size decode
  // ************************************************************
  always_comb begin
    case (boot_size_fuses)
      2'b00: boot_start = BOOT_START_SZ0;
      2'b01: boot_start = BOOT_START_SZ1;
      2'b10: boot_start = BOOT_START_SZ2;
      default: boot_start = BOOT_START_SZ3;
    endcase
  end

  // boot section runs to the top of flash
  assign in_boot_section = (pc >= boot_start);
endmodule

/* File: ivp_core_model.sv */
// core model: register cycles and instruction-end pulses towards the vector placement block
// assumes: driven by hierarchical task calls from the bench, single clock, strobes one cycle
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_core_model (
  input wire logic clk,
  output ivp_pkg::ivp_byte_t reg_addr,
  output ivp_pkg::ivp_byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic instr_done
);
  import ivp_pkg::*;

  // ************************************************************
  // bus cycles
  // ************************************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    instr_done = 1'b0;
  end

  // released lines show the inverse, so stale values cannot pass for a match
  task automatic wr(input ivp_byte_t a, input ivp_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input ivp_byte_t a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask

  // arm, then commit after gap plus one idle cycles, still inside the four-cycle window for gap up to 2
  task automatic move(input logic sel, input int gap);
    wr(`IVP_CTRL_OFS, 8'h01);
    repeat (gap) @(posedge clk);
    wr(`IVP_CTRL_OFS, {6'h00, sel, 1'b0});
  endtask

  task automatic instr();
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the vector placement control
// assumes: core model drives the register port, fuses change only across a reset
`timescale 1ns/1ps
`include "ivp_regs.svh"
module tb_top;
  import ivp_pkg::*;
  logic clk, rst_n, boot_reset_fuse, app_section_irq_lock, boot_section_irq_lock;
  logic instr_done, global_irq_enable, irq_request, reg_wr, reg_rd;
  logic irq_service, irq_block, lock_block, vector_base_select;
  logic [1:0] boot_size_fuses;
  logic [4:0] vector_num;
  ivp_byte_t reg_addr, reg_wdata, reg_rdata;
  ivp_addr_t pc, vector_base, vector_addr, reset_addr;
  int mismatches, n_compared;

  ivp_ctrl dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_size_fuses(boot_size_fuses), .boot_reset_fuse(boot_reset_fuse),
    .app_section_irq_lock(app_section_irq_lock), .boot_section_irq_lock(boot_section_irq_lock), .pc(pc),
    .instr_done(instr_done), .global_irq_enable(global_irq_enable), .irq_request(irq_request),
    .vector_num(vector_num), .irq_service(irq_service), .irq_block(irq_block), .lock_block(lock_block),
    .vector_base_select(vector_base_select), .vector_base(vector_base), .vector_addr(vector_addr),
    .reset_addr(reset_addr));
  ivp_core_model core_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .instr_done(instr_done));

  // ************************************************************
  // helpers
  // ************************************************************
  always #10 clk = ~clk;

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic brst, input logic app_lk, input logic boot_lk);
    @(posedge clk);
    rst_n <= 1'b0;
    boot_reset_fuse <= brst;
    app_section_irq_lock <= app_lk;
    boot_section_irq_lock <= boot_lk;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  task automatic read_chk(input ivp_byte_t a, input ivp_byte_t exp);
    core_u.rd(a);
    #1;
    check("rdata", reg_rdata, exp);
  endtask

  task automatic set_pc(input ivp_addr_t a);
    @(posedge clk);
    pc <= a;
    #1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_timeout();
    // first window runs out from idle, second is re-armed just before it closes
    for (int k = 0; k < 2; k++) begin
      core_u.wr(`IVP_CTRL_OFS, 8'h01);
      if (k == 1) begin
        read_chk(`IVP_CTRL_OFS, 8'h01);
        core_u.wr(`IVP_CTRL_OFS, 8'h01);
      end
      #1;
      for (int i = 0; i < 4; i++) begin
        check("irq_block", irq_block, 1'b1);
        check("irq_service", irq_service, 1'b0);
        @(posedge clk);
        #1;
      end
      check("irq_block", irq_block, 1'b0);
      check("irq_service", irq_service, 1'b1);
      read_chk(`IVP_CTRL_OFS, 8'h00);
    end
    core_u.wr(`IVP_CTRL_OFS, 8'h02);
    @(posedge clk);
    #1;
    check("sel", vector_base_select, 1'b0);
  endtask

  task automatic t_move();
    core_u.move(1'b1, 0);
    #1;
    check("sel", vector_base_select, 1'b1);
    check("irq_block", irq_block, 1'b1);
    @(posedge clk);
    #1;
    check("vector_base", vector_base, `IVP_BOOT8K_START);
    check("vector_addr", vector_addr, `IVP_BOOT8K_FIRST_IRQ);
    check("irq_block", irq_block, 1'b1);
    read_chk(`IVP_STAT_OFS, 8'h0A);
    core_u.instr();
    #1;
    check("irq_block", irq_block, 1'b0);
    check("irq_service", irq_service, 1'b1);
    read_chk(`IVP_CTRL_OFS, 8'h02);
    @(posedge clk);
    vector_num <= 5'd27;
    #1;
    check("rdata", reg_rdata, 8'h00);
    @(posedge clk);
    #1;
    check("vector_addr", vector_addr, 17'h1F036);
    core_u.wr(`IVP_CTRL_OFS, 8'h00);
    @(posedge clk);
    #1;
    check("sel", vector_base_select, 1'b1);
    core_u.wr(8'h05, 8'hFF);
    read_chk(8'h05, 8'h00);
    core_u.move(1'b0, 1);
    core_u.instr();
    @(posedge clk);
    #1;
    check("vector_base", vector_base, `IVP_APP_START);
    check("vector_addr", vector_addr, 17'h00036);
  endtask

  task automatic t_locks();
    check("reset_addr", reset_addr, `IVP_APP_START);
    set_pc(17'h1F100);
    check("lock_block", lock_block, 1'b1);
    check("irq_service", irq_service, 1'b0);
    read_chk(`IVP_STAT_OFS, 8'h14);
    set_pc(17'h00100);
    check("lock_block", lock_block, 1'b0);
    core_u.move(1'b1, 1);
    core_u.instr();
    #1;
    check("lock_block", lock_block, 1'b1);
    check("irq_service", irq_service, 1'b0);
    set_pc(17'h1F100);
    check("lock_block", lock_block, 1'b0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    boot_size_fuses = 2'b00;
    boot_reset_fuse = 1'b0;
    app_section_irq_lock = 1'b1;
    boot_section_irq_lock = 1'b1;
    pc = 17'h00100;
    global_irq_enable = 1'b1;
    irq_request = 1'b1;
    vector_num = 5'd1;
    mismatches = 0;
    n_compared = 0;
    do_reset(`IVP_FUSE_PROGRAMMED, 1'b1, 1'b1);
    check("reset_addr", reset_addr, `IVP_BOOT8K_START);
    check("vector_addr", vector_addr, 17'h00002);
    read_chk(`IVP_CTRL_OFS, `IVP_CTRL_RST);
    t_timeout();
    t_move();
    do_reset(1'b1, 1'b0, 1'b0);
    t_locks();
    wrap_up();
  end

  // cuts a hang short well inside the cycle budget
  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end
endmodule
